// [verilog/qbsp_top.sv]
// Burst SRAM device core: pin sampling, address slots, write commit buffer, read pipeline.
// Assumes the controller's clocks run far slower than clk so every input clock edge is seen.
//
// Overview of operation
// RULE1: Read data leaves on its own output port and write data enters on its own input port, both at once.
// RULE2: Every latched address moves a burst of four 18-bit words in order.
// RULE3: Read and write addresses share the address pins on alternating positive clock rises.
// RULE4: One data word moves on each rise of either input clock, two per clock period per port.
// RULE5: Only rising edges of the positive and negative input clocks are ever used.
// RULE6: With the bypass control high the first read word appears 2.5 clock periods after the address.
// RULE7: With the bypass control low the first read word appears one clock period after the address.
// RULE8: A valid flag marks each phase in which the read port carries burst data.
// RULE9: A complementary echo clock pair follows the input clock phases alongside the read data.
// RULE10: Separate read and write selects enable or ignore each port independently.
// RULE11: Every synchronous input is captured in registers on an input clock rise.
// RULE12: Every read data output comes from a register updated on an input clock rise.
// RULE13: Array writes are committed internally by the device with no further controller action.
// RULE14: A read of an address with an uncommitted write returns the newest written data; with bypass low a write addressed one rise earlier is missed.
// RULE15: The read address and the write address are latched separately from the one address bus.
// RULE16: The controller selects a port only in that port's slot and holds write data for all four words.
`timescale 1ns/100ps
`default_nettype none

module qbsp_fifo
    import qbsp_pkg::*;
#(
    parameter int W = 8,
    parameter int D = 2
)(
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  rstn,
    // Fill side
    input  wire logic                  in_valid,
    input  wire logic [W-1:0]          in_data,
    output logic                       in_ready,
    // Drain side
    output logic                       out_valid,
    output logic [W-1:0]               out_data,
    input  wire logic                  out_ready,
    // Contents, oldest first
    output logic [D-1:0][W-1:0]        peek_data,
    output logic [D-1:0]               peek_vld
);

    localparam int PW = (D > 1) ? $clog2(D) : 1;
    localparam int CW = $clog2(D + 1);

    typedef struct packed {
        logic [D-1:0][W-1:0]  mem;
        logic [PW-1:0]        rp;
        logic [PW-1:0]        wp;
        logic [CW-1:0]        cnt;
    } qbsp_fifo_st_t;

    qbsp_fifo_st_t q_ff;
    qbsp_fifo_st_t nxt_q;
    logic          push;
    logic          pop;

    assign in_ready  = (q_ff.cnt != CW'(D));
    assign out_valid = (q_ff.cnt != '0);
    assign out_data  = q_ff.mem[q_ff.rp];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always_comb
    begin
        nxt_q = q_ff;
        if (push)
        begin
            nxt_q.mem[q_ff.wp] = in_data;
            nxt_q.wp           = q_ff.wp + PW'(1);
        end
        if (pop)
        begin
            nxt_q.rp = q_ff.rp + PW'(1);
        end
        nxt_q.cnt = q_ff.cnt + CW'(push) - CW'(pop);
    end

    always_comb
    begin
        for (int i = 0; i < D; i++)
        begin
            peek_data[i] = q_ff.mem[q_ff.rp + PW'(i)];
            peek_vld[i]  = (CW'(i) < q_ff.cnt);
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            q_ff <= '0;
        else
            q_ff <= nxt_q;
    end

endmodule // qbsp_fifo

module qbsp_top
    import qbsp_pkg::*;
(
    // System clock and reset
    input  wire logic                  clk,
    input  wire logic                  rstn,
    // Input clock pair from the controller
    input  wire logic                  k_clk,
    input  wire logic                  k_clk_n,
    // Latency mode strap
    input  wire logic                  pll_bypass_select,
    // Address and port selects
    input  wire logic                  rd_sel_n,
    input  wire logic                  wr_sel_n,
    input  wire logic [AW-1:0]         addr,
    // Write port
    input  wire logic [DW-1:0]         wdata,
    input  wire logic [BW-1:0]         byte_write_enable_n,
    output logic                       wr_buf_ready,
    // Read port
    output logic [DW-1:0]              rdata,
    output logic                       read_valid_flag,
    output logic                       echo_clock_out,
    output logic                       echo_clock_out_n
);

    typedef struct packed {
        qbsp_pins_t                       s1;
        qbsp_pins_t                       s2;
        logic                             k_d;
        logic                             kn_d;
        logic                             slot;
        logic                             wcol_act;
        logic                             wcol_full;
        logic [1:0]                       wcol_idx;
        qbsp_wburst_t                     wcol;
        qbsp_wburst_t                     whold;
        qbsp_rpend_t [1:0]                pend;
        logic                             pwr;
        logic                             prd;
        logic                             act_vld;
        logic [1:0]                       act_idx;
        qbsp_words_t                      act_data;
        logic [DW-1:0]                    rdata;
        logic                             rvalid;
        logic                             echo;
        logic [DEPTH-1:0][BURST*DW-1:0]   mem;
    } qbsp_state_t;

    qbsp_state_t                     q_ff;
    qbsp_state_t                     nxt_q;
    qbsp_pins_t                      pins;
    logic                            k_rise;
    logic                            kn_rise;
    logic                            phase;
    logic [CNT_W-1:0]                lat_ph;
    logic                            lookup;
    logic [AW-1:0]                   look_addr;
    qbsp_words_t                     merged;
    logic                            buf_out_valid;
    logic [WB_W-1:0]                 buf_out_raw;
    qbsp_wburst_t                    buf_out;
    logic [WBUF_D-1:0][WB_W-1:0]     buf_peek;
    logic [WBUF_D-1:0]               buf_peek_vld;
    qbsp_wburst_t [WBUF_D-1:0]       buf_peek_wb;

    // Overlay one burst onto a set of words, honouring the active-low byte enables.
    function automatic qbsp_words_t overlay(input qbsp_words_t base, input qbsp_wburst_t wb);
        qbsp_words_t res;
        res = base;
        for (int w = 0; w < BURST; w++)
        begin
            for (int l = 0; l < BW; l++)
            begin
                if (!wb.be_n[w][l])
                    res[w][l*LANE +: LANE] = wb.data[w][l*LANE +: LANE];
            end
        end
        return res;
    endfunction

    // The negative clock is stored inverted, so its reset value matches its idle high level
    // and no false rise is seen when reset lets go.
    assign pins = '{k: k_clk, k_n: ~k_clk_n, pll_bypass_select: pll_bypass_select,
                    rd_sel_n: rd_sel_n, wr_sel_n: wr_sel_n, addr: addr,
                    wdata: wdata, byte_write_enable_n: byte_write_enable_n};

    // Falling edges are deliberately never decoded.
    assign k_rise  = q_ff.s2.k & ~q_ff.k_d; // RULE5
    assign kn_rise = ~q_ff.s2.k_n & q_ff.kn_d; // RULE5
    assign phase   = k_rise | kn_rise; // RULE4
    assign lat_ph  = q_ff.s2.pll_bypass_select ? LAT_PLL_PH : LAT_BYP_PH; // RULE6 RULE7

    // Launch of a pending read is the only cycle in which the read port reads the array; the commit waits in that cycle.
    assign lookup    = phase & q_ff.pend[q_ff.prd].vld & (q_ff.pend[q_ff.prd].cnt == '0);
    assign look_addr = q_ff.pend[q_ff.prd].addr;
    assign buf_out   = qbsp_wburst_t'(buf_out_raw);
    // Typed view of the buffer contents for the coherency lookup.
    assign buf_peek_wb = buf_peek;

    // Newest data wins: array, then buffered bursts oldest first, then the held burst.
    always_comb
    begin
        merged = qbsp_words_t'(q_ff.mem[look_addr]);
        for (int e = 0; e < WBUF_D; e++)
        begin
            if (buf_peek_vld[e] && (buf_peek_wb[e].addr == look_addr))
                merged = overlay(merged, buf_peek_wb[e]); // RULE14
        end
        // A partly collected burst is not merged, as its later words are not yet known.
        if (q_ff.wcol_full && (q_ff.whold.addr == look_addr))
            merged = overlay(merged, q_ff.whold); // RULE14
    end

    // A held burst waits here while the commit buffer is full, so no write is lost.
    qbsp_fifo #(
        .W (WB_W),
        .D (WBUF_D)
    ) u_wbuf (
        .clk       (clk),
        .rstn      (rstn),
        .in_valid  (q_ff.wcol_full),
        .in_data   (q_ff.whold),
        .in_ready  (wr_buf_ready),
        .out_valid (buf_out_valid),
        .out_data  (buf_out_raw),
        .out_ready (~lookup),
        .peek_data (buf_peek),
        .peek_vld  (buf_peek_vld)
    );

    always_comb
    begin
        nxt_q = q_ff;

        // Two flip-flops on every pin before any logic looks at it.
        nxt_q.s1   = pins; // RULE11
        nxt_q.s2   = q_ff.s1;
        nxt_q.k_d  = q_ff.s2.k;
        nxt_q.kn_d = q_ff.s2.k_n;

        // Write burst collection, one word per phase after the write address.
        // The clear comes first so that a burst completing in the same cycle keeps its flag.
        if (q_ff.wcol_full && wr_buf_ready)
            nxt_q.wcol_full = 1'b0;
        if (phase && q_ff.wcol_act)
        begin
            nxt_q.wcol.data[q_ff.wcol_idx] = q_ff.s2.wdata; // RULE1 RULE11 RULE16
            nxt_q.wcol.be_n[q_ff.wcol_idx] = q_ff.s2.byte_write_enable_n; // RULE11
            nxt_q.wcol_idx                 = q_ff.wcol_idx + 2'h1; // RULE2
            if (q_ff.wcol_idx == LAST_WORD)
            begin
                nxt_q.wcol_act  = 1'b0;
                nxt_q.wcol_full = 1'b1;
                nxt_q.whold     = nxt_q.wcol; // RULE2
            end
        end

        // Self-timed commit of the oldest buffered burst into the array.
        if (buf_out_valid && !lookup)
            nxt_q.mem[buf_out.addr] = overlay(qbsp_words_t'(q_ff.mem[buf_out.addr]), buf_out); // RULE13

        // Pending read latency countdown in phases.
        if (phase)
        begin
            for (int i = 0; i < 2; i++)
            begin
                if (q_ff.pend[i].vld && (q_ff.pend[i].cnt != '0))
                    nxt_q.pend[i].cnt = q_ff.pend[i].cnt - 3'h1; // RULE6 RULE7
            end
        end

        // Read port launch; each word sits in a register for one phase.
        if (lookup)
        begin
            nxt_q.rdata             = merged[0]; // RULE12 RULE1
            nxt_q.rvalid            = 1'b1; // RULE8
            nxt_q.act_data          = merged;
            nxt_q.act_idx           = 2'h1;
            nxt_q.act_vld           = 1'b1;
            nxt_q.pend[q_ff.prd].vld = 1'b0;
            nxt_q.prd               = ~q_ff.prd;
        end
        else if (phase && q_ff.act_vld)
        begin
            nxt_q.rdata   = q_ff.act_data[q_ff.act_idx]; // RULE12 RULE2
            nxt_q.rvalid  = 1'b1; // RULE8
            nxt_q.act_idx = q_ff.act_idx + 2'h1;
            if (q_ff.act_idx == LAST_WORD)
                nxt_q.act_vld = 1'b0;
        end
        else if (phase)
        begin
            nxt_q.rvalid = 1'b0; // RULE8
        end

        // Echo clocks follow the input clock rises.
        if (k_rise)
            nxt_q.echo = 1'b1; // RULE9
        else if (kn_rise)
            nxt_q.echo = 1'b0; // RULE9

        // Address slots alternate on positive clock rises, read slot first after reset.
        if (k_rise)
        begin
            nxt_q.slot = ~q_ff.slot; // RULE3
            if ((q_ff.slot == SLOT_RD) && !q_ff.s2.rd_sel_n) // RULE10 RULE16
            begin
                nxt_q.pend[q_ff.pwr].vld  = 1'b1; // RULE15
                nxt_q.pend[q_ff.pwr].cnt  = lat_ph - 3'h1; // RULE6 RULE7
                nxt_q.pend[q_ff.pwr].addr = q_ff.s2.addr; // RULE15
                nxt_q.pwr                 = ~q_ff.pwr;
            end
            // A write address is refused while the previous burst is still held. The last
            // word of a running burst shares its clock rise with the next write address,
            // so a burst that finishes on this rise does not block the next one.
            if ((q_ff.slot == SLOT_WR) && !q_ff.s2.wr_sel_n && // RULE10 RULE16
                !q_ff.wcol_full && (!q_ff.wcol_act || (q_ff.wcol_idx == LAST_WORD)))
            begin
                nxt_q.wcol.addr = q_ff.s2.addr; // RULE15
                nxt_q.wcol_act  = 1'b1;
                nxt_q.wcol_idx  = 2'h0;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            q_ff <= '0;
        else
            q_ff <= nxt_q;
    end

    assign rdata            = q_ff.rdata; // RULE12
    assign read_valid_flag  = q_ff.rvalid; // RULE8
    assign echo_clock_out   = q_ff.echo; // RULE9
    assign echo_clock_out_n = ~q_ff.echo; // RULE9

endmodule // qbsp_top

`default_nettype wire

// [verilog/qbsp_pkg.sv]
// Constants and carrier types for the four-word burst SRAM port.
// Assumes one system clock domain; all link pins are sampled by that clock.
package qbsp_pkg;

    // Data path geometry of the narrow variant.
    localparam int DW      = 18;
    localparam int BW      = 2;
    localparam int LANE    = 9;
    localparam int BURST   = 4;
    localparam int AW      = 4;
    localparam int DEPTH   = 16;
    localparam int WBUF_D  = 2;

    // Read latency counted in clock phases, one phase per rising edge of either input clock.
    localparam int          CNT_W      = 3;
    localparam logic [2:0]  LAT_PLL_PH = 3'h5;
    localparam logic [2:0]  LAT_BYP_PH = 3'h2;

    // Address slot order on the rising edges of the positive input clock.
    localparam logic        SLOT_RD    = 1'h0;
    localparam logic        SLOT_WR    = 1'h1;
    localparam logic [1:0]  LAST_WORD  = 2'h3;

    typedef logic [BURST-1:0][DW-1:0] qbsp_words_t;

    typedef struct packed {
        logic                 k;
        logic                 k_n;
        logic                 pll_bypass_select;
        logic                 rd_sel_n;
        logic                 wr_sel_n;
        logic [AW-1:0]        addr;
        logic [DW-1:0]        wdata;
        logic [BW-1:0]        byte_write_enable_n;
    } qbsp_pins_t;

    typedef struct packed {
        logic [AW-1:0]                addr;
        logic [BURST-1:0][BW-1:0]     be_n;
        qbsp_words_t                  data;
    } qbsp_wburst_t;

    localparam int WB_W = $bits(qbsp_wburst_t);

    typedef struct packed {
        logic                 vld;
        logic [CNT_W-1:0]     cnt;
        logic [AW-1:0]        addr;
    } qbsp_rpend_t;

endpackage

// [tb/qbsp_top_chk.sv]
// Pin-level assertions for the burst SRAM port.
// Assumes echo clock changes mark the phase events of the read port.
`timescale 1ns/100ps
`default_nettype none
module qbsp_top_chk
    import qbsp_pkg::*;
(
    // Clock and reset
    input  wire logic          clk,
    input  wire logic          rstn,
    // Link inputs
    input  wire logic          k_clk,
    input  wire logic          k_clk_n,
    input  wire logic          pll_bypass_select,
    input  wire logic          rd_sel_n,
    // Read port
    input  wire logic [DW-1:0] rdata,
    input  wire logic          read_valid_flag,
    input  wire logic          echo_clock_out,
    input  wire logic          echo_clock_out_n
);
    logic       echo_ff;
    logic       slot_ff;
    logic       sel1_ff;
    logic       sel2_ff;
    logic [1:0] word_ff;
    wire logic  phase = echo_clock_out != echo_ff;
    wire logic  rd_go = echo_clock_out && !echo_ff && !slot_ff && !sel2_ff;
    wire logic  start = phase && read_valid_flag && word_ff == 2'h0;

    // The select is looked at two cycles back, where it is steady around the clock rise.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            echo_ff <= 1'h0;
            slot_ff <= 1'h0;
            sel1_ff <= 1'h1;
            sel2_ff <= 1'h1;
            word_ff <= 2'h0;
        end
        else
        begin
            echo_ff <= echo_clock_out;
            sel1_ff <= rd_sel_n;
            sel2_ff <= sel1_ff;
            if (echo_clock_out && !echo_ff)
                slot_ff <= !slot_ff;
            if (phase && read_valid_flag)
                word_ff <= word_ff + 2'h1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence s_long;
        rd_go && pll_bypass_select;
    endsequence
    sequence s_short;
        rd_go && !pll_bypass_select;
    endsequence

    a_echo_inv: assert property (echo_clock_out_n == !echo_clock_out)
        else $error("echo pair not complementary");
    a_echo_on_k: assert property ($rose(echo_clock_out) |-> $past(k_clk, 2) && !$past(k_clk, 5))
        else $error("echo rise without input clock rise");
    a_echo_on_kn: assert property ($fell(echo_clock_out) |-> $past(k_clk_n, 2) && !$past(k_clk_n, 5))
        else $error("echo fall without negative clock rise");
    a_data_phase: assert property ($changed(rdata) |-> phase)
        else $error("read data changed between phases");
    a_valid_phase: assert property ($changed(read_valid_flag) |-> phase)
        else $error("valid flag changed between phases");
    a_burst_four: assert property ($fell(read_valid_flag) |-> word_ff == 2'h0)
        else $error("burst not four words long");
    a_lat_long: assert property (s_long |-> ##20 start)
        else $error("long read latency wrong");
    a_lat_short: assert property (s_short |-> ##8 start)
        else $error("short read latency wrong");
    a_burst_cause: assert property (start |-> (pll_bypass_select ? $past(rd_go, 20) : $past(rd_go, 8)))
        else $error("burst without selected read");
endmodule // qbsp_top_chk
bind qbsp_top qbsp_top_chk u_chk (.clk(clk), .rstn(rstn), .k_clk(k_clk), .k_clk_n(k_clk_n),
    .pll_bypass_select(pll_bypass_select), .rd_sel_n(rd_sel_n), .rdata(rdata),
    .read_valid_flag(read_valid_flag), .echo_clock_out(echo_clock_out),
    .echo_clock_out_n(echo_clock_out_n));
`default_nettype wire

// [tb/qbsp_ctl_model.sv]
// Memory controller model: input clock pair, address slots and write bursts.
// Assumes its clock starts only after reset so the first rise is the read slot.
`timescale 1ns/100ps
`default_nettype none
module qbsp_ctl_model
    import qbsp_pkg::*;
(
    // Reset seen by the controller
    input  wire logic                rstn,
    // Clock pair
    output logic                     k_clk,
    output logic                     k_clk_n,
    // Selects and address
    output logic                     rd_sel_n,
    output logic                     wr_sel_n,
    output logic [AW-1:0]            addr,
    // Write port
    output logic [DW-1:0]            wdata,
    output logic [BW-1:0]            byte_write_enable_n
);
    typedef struct packed {
        logic         rd;
        logic [AW-1:0] ra;
        logic         wr;
        logic         bad;
        qbsp_wburst_t wb;
    } qbsp_pair_t;
    qbsp_pair_t   q [$];
    qbsp_pair_t   p;
    qbsp_wburst_t cur;
    int           left;
    int           e;

    task automatic push(logic rd, logic [AW-1:0] ra, logic wr, logic bad, qbsp_wburst_t wb);
        q.push_back({rd, ra, wr, bad, wb});
    endtask
    function automatic logic busy();
        return q.size() > 0 || left > 0 || p.wr || p.bad;
    endfunction

    // Unused lines toggle so that a stale value is never mistaken for data.
    initial
    begin
        k_clk = 1'h0;
        k_clk_n = 1'h1;
        rd_sel_n = 1'h1;
        wr_sel_n = 1'h1;
        addr = '0;
        wdata = '0;
        byte_write_enable_n = '0;
        p = '0;
        left = 0;
        e = 0;
        wait (rstn);
        forever
        begin
            #80;
            if (left > 0)
            begin
                wdata = cur.data[BURST-left];
                byte_write_enable_n = cur.be_n[BURST-left];
                left--;
            end
            else
            begin
                wdata = ~wdata;
                byte_write_enable_n = ~byte_write_enable_n;
            end
            rd_sel_n = 1'h1;
            wr_sel_n = 1'h1;
            addr = ~addr;
            if (e % 4 == 0 && q.size() > 0)
            begin
                p = q.pop_front();
                rd_sel_n = !p.rd;
                wr_sel_n = !p.bad;
                if (p.rd || p.bad)
                    addr = p.ra;
            end
            else if (e % 4 == 2 && (p.wr || p.bad))
            begin
                rd_sel_n = !p.bad;
                wr_sel_n = !p.wr;
                addr = p.wb.addr;
                cur = p.wb;
                left = p.wr ? BURST : 0;
                p = '0;
            end
            #80;
            k_clk = e % 2 == 0;
            k_clk_n = !k_clk;
            e++;
        end
    end
endmodule // qbsp_ctl_model
`default_nettype wire

// [tb/tb_top.sv]
// Self-checking bench of the burst SRAM port with a controller model.
// Assumes a 40 ns system clock and a 320 ns input clock from the model.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import qbsp_pkg::*;
    logic          clk, rstn, k_clk, k_clk_n, pll, rd_sel_n, wr_sel_n;
    logic          wr_buf_ready, rvalid, echo, echo_n, echo_q;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata, rdata;
    logic [BW-1:0] be_n;
    int            err_count, cmp_count, cyc, seed, gap, i;
    qbsp_words_t   mem [DEPTH];
    logic [DW-1:0] exp_q [$];

    qbsp_ctl_model u_ctl (.rstn(rstn), .k_clk(k_clk), .k_clk_n(k_clk_n), .rd_sel_n(rd_sel_n),
        .wr_sel_n(wr_sel_n), .addr(addr), .wdata(wdata), .byte_write_enable_n(be_n));
    qbsp_top DUT (.clk(clk), .rstn(rstn), .k_clk(k_clk), .k_clk_n(k_clk_n),
        .pll_bypass_select(pll), .rd_sel_n(rd_sel_n), .wr_sel_n(wr_sel_n), .addr(addr),
        .wdata(wdata), .byte_write_enable_n(be_n), .wr_buf_ready(wr_buf_ready), .rdata(rdata),
        .read_valid_flag(rvalid), .echo_clock_out(echo), .echo_clock_out_n(echo_n));

    task automatic stop_test();
        if (err_count == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic check(string what, logic [DW-1:0] exp, logic [DW-1:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Reads take the memory image before this pair's write, as the read slot comes first.
    task automatic pair(logic rd, logic [AW-1:0] ra, logic wr, logic [AW-1:0] wa, logic bad);
        qbsp_wburst_t wb;
        int w, b;
        wb.addr = wa;
        for (w = 0; w < BURST; w++)
        begin
            wb.data[w] = DW'($random(seed));
            wb.be_n[w] = BW'($random(seed));
            if (rd)
                exp_q.push_back(mem[ra][w]);
            for (b = 0; b < DW; b++)
                if (wr && !wb.be_n[w][b/LANE])
                    mem[wa][w][b] = wb.data[w][b];
        end
        u_ctl.push(rd, ra, wr, bad, wb);
    endtask
    task automatic drain();
        int n;
        for (n = 0; n < 2000 && (u_ctl.busy() || exp_q.size() > 0); n++)
            @(posedge clk);
        repeat (40) @(posedge clk);
        #1;
    endtask

    initial
    begin
        clk = 1'h0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 6000)
        begin
            check("cycle limit", 18'h0, 18'h1);
            stop_test();
        end
    end
    // Read words are captured mid-phase, two cycles after the echo clock moves.
    always @(negedge clk)
    begin
        if (echo !== echo_q)
            gap = 0;
        else
            gap++;
        echo_q = echo;
        if (gap == 2 && rvalid === 1'h1)
        begin
            if (exp_q.size() == 0)
                check("read_valid_flag", 18'h0, 18'h1);
            else
                check("rdata", exp_q.pop_front(), rdata);
        end
    end

    initial
    begin
        seed = 32'hbf9c;
        rstn = 1'h0;
        pll = 1'h1;
        for (i = 0; i < DEPTH; i++)
            mem[i] = '0;
        repeat (12) @(posedge clk);
        #1 rstn = 1'h1;
        for (i = 0; i < DEPTH; i++)
            pair(i > 0, AW'(i - 1), 1'h1, AW'(i), 1'h0);
        pair(1'h1, AW'(15), 1'h0, AW'(0), 1'h0);
        pair(1'h0, AW'(5), 1'h0, AW'(5), 1'h1);
        pair(1'h1, AW'(5), 1'h0, AW'(0), 1'h0);
        drain();
        pll = 1'h0;
        for (i = 0; i < 24; i++)
            pair(1'($random(seed)), {1'h1, 3'($random(seed))}, 1'($random(seed)), AW'(i % 8), 1'h0);
        drain();
        for (i = 0; i < 8; i++)
            pair(1'h1, AW'(i), 1'h0, AW'(0), 1'h0);
        drain();
        check("wr_buf_ready", 18'h1, {17'h0, wr_buf_ready});
        check("pending words", 18'h0, DW'(exp_q.size()));
        stop_test();
    end
endmodule // tb_top
`default_nettype wire
